// ### core/pswm_pkg.sv
package pswm_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned HOLD_TIME_S      = 4;
  localparam longint unsigned HOLD_CYCLES  = longint'(HOLD_TIME_S) * 1000000 * CLK_MHZ;
  localparam int unsigned DEBOUNCE_TIME_US = 10;
  localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 32;
  localparam int unsigned DB_W             = 16;

  localparam int unsigned NUM_RAILS  = 5;
  localparam int unsigned NUM_FANS   = 3;
  localparam int unsigned TEMP_W     = 8;
  localparam int unsigned ADC_W      = 10;
  localparam int unsigned DUTY_W     = 8;

  // graphics_memory_hub floor, degrees C
  localparam logic [7:0] GMH_FLOOR_C = 8'h42;

  localparam logic [7:0] FAN_TEMP_LO = 8'h28;
  localparam logic [7:0] FAN_TEMP_HI = 8'h50;
  localparam logic [7:0] DUTY_MIN    = 8'h40;
  localparam logic [7:0] DUTY_MAX    = 8'hFF;
  localparam logic [7:0] DUTY_STEP   = 8'h01;
  localparam logic [7:0] DUTY_RESET  = 8'h00;

  typedef enum logic [2:0] {
    PSWM_S0 = 3'b000,
    PSWM_S1 = 3'b001,
    PSWM_S3 = 3'b011,
    PSWM_S4 = 3'b100,
    PSWM_S5 = 3'b101
  } pswm_state_t;

  // wake source bundle
  typedef struct packed {
    logic lan;
    logic pme;
    logic rtc;
    logic pcie;
    logic ps2;
    logic serial;
    logic usb;
  } pswm_wake_t;

  typedef struct packed {
    logic go_s1;
    logic go_s3;
    logic go_s4;
    logic soft_off;
  } pswm_cmd_t;

  typedef struct packed {
    logic [ADC_W-1:0] lo;
    logic [ADC_W-1:0] hi;
  } pswm_window_t;

  function automatic logic pswm_is_sleep(input pswm_state_t s);
    return (s == PSWM_S1) || (s == PSWM_S3) || (s == PSWM_S4);
  endfunction

  function automatic logic pswm_deep(input pswm_state_t s);
    return (s == PSWM_S4) || (s == PSWM_S5);
  endfunction

endpackage

// ### core/pswm_debounce.sv
`timescale 1ns/1ps
module pswm_debounce
  import pswm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw,
  output logic      clean
);
  logic [DB_W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (raw == clean) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + DB_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clean <= 1'b0;
    end else if ((raw != clean) && (cnt_q >= DB_W'(DEBOUNCE_CYCLES - 1))) begin
      clean <= raw;
    end
  end
endmodule

// ### core/pswm_fan_loop.sv
`timescale 1ns/1ps
module pswm_fan_loop
  import pswm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              run,
  input  wire logic              tick,
  input  wire logic [TEMP_W-1:0] temp,
  output logic      [DUTY_W-1:0] duty
);
  logic [DUTY_W-1:0] target;

  always_comb begin
    if (temp <= FAN_TEMP_LO) begin
      target = DUTY_MIN;
    end else if (temp >= FAN_TEMP_HI) begin
      target = DUTY_MAX;
    end else begin
      target = DUTY_MIN + DUTY_W'((temp - FAN_TEMP_LO) << 2);
    end
  end

  // duty snaps up to DUTY_MIN, then slews one step per tick toward the thermal target
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty <= DUTY_RESET;
    end else if (!run) begin
      duty <= DUTY_RESET;
    end else if (duty < DUTY_MIN) begin
      duty <= DUTY_MIN;
    end else if (tick && (duty < target)) begin
      duty <= duty + DUTY_STEP;
    end else if (tick && (duty > target)) begin
      duty <= duty - DUTY_STEP;
    end
  end
endmodule

// ### core/pswm_top.sv
// Operation
// - short press: off->on, on->sleep, sleep->on
// - long press forces soft-off from on/sleep
// - wake sources gated by permitted sleep states
// - usb power removed in S4 and S5
// - pcie wake honored only when enabled
// - closed intrusion switch flags intrusion
// - hub temperature reported no lower than floor
// - flag each of five rails out of window
// - closed-loop speed for three fans
// - soft-off command in S0 removes power, enters S5
// - fans on in S0, off otherwise
`timescale 1ns/1ps
module pswm_top
  import pswm_pkg::*;
#(
  parameter longint unsigned HOLD_LIMIT = HOLD_CYCLES
) (
  input  wire logic                          MCLK,
  input  wire logic                          RST_N,
  input  wire logic                          PWR_SW,
  input  wire pswm_pkg::pswm_wake_t          WAKE_IN,
  input  wire logic                          PCIE_WAKE_EN,
  input  wire pswm_pkg::pswm_cmd_t           OS_CMD,
  input  wire logic                          INTRUSION_SW,
  input  wire logic                          INTRUSION_CLR,
  input  wire logic [pswm_pkg::TEMP_W-1:0]   HUB_TEMP_RAW,
  input  wire logic [pswm_pkg::TEMP_W-1:0]   CPU_TEMP,
  input  wire logic [pswm_pkg::TEMP_W-1:0]   AMB_TEMP,
  input  wire logic [pswm_pkg::ADC_W-1:0]    RAIL_LVL [pswm_pkg::NUM_RAILS],
  input  wire pswm_pkg::pswm_window_t        RAIL_WIN [pswm_pkg::NUM_RAILS],
  input  wire logic                          FAN_TICK,
  output pswm_pkg::pswm_state_t              SLEEP_STATE,
  output logic                               SYS_PWR_EN,
  output logic                               USB_PWR_EN,
  output logic                               FAN_EN,
  output logic [pswm_pkg::DUTY_W-1:0]        FAN_DUTY [pswm_pkg::NUM_FANS],
  output logic                               INTRUSION,
  output logic [pswm_pkg::TEMP_W-1:0]        HUB_TEMP,
  output logic [pswm_pkg::NUM_RAILS-1:0]     RAIL_FAULT,
  output logic                               WAKE_EVENT
);
  import pswm_pkg::*;

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        rst_n;
  logic        sw_clean;
  logic        sw_prev_q;
  logic [CNT_W-1:0] hold_q;
  logic        long_q;
  logic        release_ev;
  logic        short_press;
  logic        long_press;
  logic        wake_ok;
  pswm_state_t state_q;
  pswm_state_t state_d;
  logic [DUTY_W-1:0] duty [NUM_FANS];
  logic [TEMP_W-1:0] fan_temp [NUM_FANS];

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  pswm_debounce u_db (
    .clk   (MCLK),
    .rst_n (rst_n),
    .raw   (PWR_SW),
    .clean (sw_clean)
  );

  // press duration counter, saturating
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (!sw_clean) begin
      hold_q <= '0;
    end else if (hold_q < CNT_W'(HOLD_LIMIT)) begin
      hold_q <= hold_q + CNT_W'(1);
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sw_prev_q <= 1'b0;
      long_q    <= 1'b0;
    end else begin
      sw_prev_q <= sw_clean;
      if (!sw_clean) begin
        long_q <= 1'b0;
      end else if (long_press) begin
        long_q <= 1'b1;
      end
    end
  end

  // long press acts once, at threshold; short press acts on release
  assign long_press  = sw_clean && !long_q && (hold_q == CNT_W'(HOLD_LIMIT));
  assign release_ev  = sw_prev_q && !sw_clean;
  assign short_press = release_ev && !long_q;

  // wake gating per sleep state
  always_comb begin
    wake_ok = 1'b0;
    if (pswm_is_sleep(state_q) || (state_q == PSWM_S5)) begin
      wake_ok = WAKE_IN.lan || WAKE_IN.pme || WAKE_IN.rtc || WAKE_IN.ps2
             || (WAKE_IN.pcie && PCIE_WAKE_EN);
      if (!pswm_deep(state_q)) begin
        wake_ok = wake_ok || WAKE_IN.serial || WAKE_IN.usb;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      PSWM_S0: begin
        if (long_press || OS_CMD.soft_off) begin
          state_d = PSWM_S5;
        end else if (short_press || OS_CMD.go_s3) begin
          state_d = PSWM_S3;
        end else if (OS_CMD.go_s1) begin
          state_d = PSWM_S1;
        end else if (OS_CMD.go_s4) begin
          state_d = PSWM_S4;
        end
      end
      PSWM_S1, PSWM_S3, PSWM_S4: begin
        if (long_press) begin
          state_d = PSWM_S5;
        end else if (short_press || wake_ok) begin
          state_d = PSWM_S0;
        end
      end
      PSWM_S5: begin
        if (short_press || wake_ok) begin
          state_d = PSWM_S0;
        end
      end
      default: state_d = PSWM_S5;
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= PSWM_S5;
      WAKE_EVENT <= 1'b0;
    end else begin
      state_q    <= state_d;
      WAKE_EVENT <= (state_q != PSWM_S0) && wake_ok;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      SYS_PWR_EN <= 1'b0;
      USB_PWR_EN <= 1'b0;
      FAN_EN     <= 1'b0;
    end else begin
      SYS_PWR_EN <= (state_d == PSWM_S0) || (state_d == PSWM_S1);
      USB_PWR_EN <= !pswm_deep(state_d);
      FAN_EN     <= (state_d == PSWM_S0);
    end
  end
  assign SLEEP_STATE = state_q;

  // intrusion latch; a closed switch beats a clear
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      INTRUSION <= 1'b0;
    end else if (INTRUSION_SW) begin
      INTRUSION <= 1'b1;
    end else if (INTRUSION_CLR) begin
      INTRUSION <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      HUB_TEMP <= GMH_FLOOR_C;
    end else if (HUB_TEMP_RAW <= GMH_FLOOR_C) begin
      HUB_TEMP <= GMH_FLOOR_C;
    end else begin
      HUB_TEMP <= HUB_TEMP_RAW;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RAIL_FAULT <= '0;
    end else begin
      for (int i = 0; i < NUM_RAILS; i++) begin
        RAIL_FAULT[i] <= (RAIL_LVL[i] > RAIL_WIN[i].hi) || (RAIL_LVL[i] < RAIL_WIN[i].lo);
      end
    end
  end

  assign fan_temp[0] = CPU_TEMP;
  assign fan_temp[1] = AMB_TEMP;
  assign fan_temp[2] = HUB_TEMP;

  for (genvar f = 0; f < NUM_FANS; f++) begin : g_fan
    pswm_fan_loop u_fan (
      .clk   (MCLK),
      .rst_n (rst_n),
      .run   (FAN_EN),
      .tick  (FAN_TICK),
      .temp  (fan_temp[f]),
      .duty  (duty[f])
    );
    assign FAN_DUTY[f] = duty[f];
  end

  property p_long_off;
    @(posedge MCLK) disable iff (!rst_n)
      long_press |=> (state_q == PSWM_S5);
  endproperty
  a_long_off: assert property (p_long_off) else $error("long press did not power off");

  sequence s_short_in_s5;
    (state_q == PSWM_S5) && short_press;
  endsequence
  property p_short_on;
    @(posedge MCLK) disable iff (!rst_n)
      s_short_in_s5 |=> (state_q == PSWM_S0) ##1 SYS_PWR_EN;
  endproperty
  a_short_on: assert property (p_short_on) else $error("short press did not power on");

  property p_usb_deep;
    @(posedge MCLK) disable iff (!rst_n)
      pswm_deep(state_q) && $stable(state_q) |-> !USB_PWR_EN;
  endproperty
  a_usb_deep: assert property (p_usb_deep) else $error("usb powered in deep sleep");

  property p_usb_nowake;
    @(posedge MCLK) disable iff (!rst_n)
      (state_q == PSWM_S4) && !wake_ok && !short_press && !long_press |=> (state_q == PSWM_S4);
  endproperty
  a_usb_nowake: assert property (p_usb_nowake) else $error("spurious wake from S4");

  property p_pcie_gate;
    @(posedge MCLK) disable iff (!rst_n)
      pswm_deep(state_q) && !PCIE_WAKE_EN && !short_press && !long_press
        && WAKE_IN == pswm_wake_t'{pcie: 1'b1, default: 1'b0} |=> $stable(state_q);
  endproperty
  a_pcie_gate: assert property (p_pcie_gate) else $error("disabled pcie wake acted");

  property p_intr;
    @(posedge MCLK) disable iff (!rst_n)
      INTRUSION_SW |=> INTRUSION;
  endproperty
  a_intr: assert property (p_intr) else $error("intrusion not flagged");

  property p_floor;
    @(posedge MCLK) disable iff (!rst_n)
      HUB_TEMP >= GMH_FLOOR_C;
  endproperty
  a_floor: assert property (p_floor) else $error("hub temperature below floor");

  property p_rail;
    @(posedge MCLK) disable iff (!rst_n)
      (RAIL_LVL[0] > RAIL_WIN[0].hi) |=> RAIL_FAULT[0];
  endproperty
  a_rail: assert property (p_rail) else $error("rail over window not flagged");

  property p_fan_off;
    @(posedge MCLK) disable iff (!rst_n)
      (state_q == PSWM_S3) ##1 (state_q == PSWM_S3) |-> !FAN_EN ##1 (FAN_DUTY[0] == DUTY_RESET);
  endproperty
  a_fan_off: assert property (p_fan_off) else $error("fan running in S3");

  property p_soft_off;
    @(posedge MCLK) disable iff (!rst_n)
      (state_q == PSWM_S0) && OS_CMD.soft_off |=> !SYS_PWR_EN && (state_q == PSWM_S5);
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("soft-off not taken");

endmodule

// ### bench/pswm_switch_model.sv
`timescale 1ns/1ps
module pswm_switch_model (
  input  wire logic clk,
  output logic      sw
);
  initial sw = 1'b0;
  // switch held for n cycles, then let go
  task automatic press(input int n);
    @(posedge clk) sw <= 1'b1;
    repeat (n) @(posedge clk);
    sw <= 1'b0;
    // debouncer must see the release, else a new press merges with it
    repeat (pswm_pkg::DEBOUNCE_CYCLES + 4) @(posedge clk);
  endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  import pswm_pkg::*;
  // debounced press lasts as long as the raw one: short below, long above
  localparam int HOLD  = 2600;
  localparam int SHORT = 2520;
  localparam int LONG  = 2700;
  logic                 MCLK, RST_N, PWR_SW, PCIE_WAKE_EN, FAN_TICK;
  logic                 INTRUSION_SW, INTRUSION_CLR;
  pswm_wake_t           WAKE_IN;
  pswm_cmd_t            OS_CMD;
  logic [TEMP_W-1:0]    HUB_TEMP_RAW, CPU_TEMP, AMB_TEMP, HUB_TEMP;
  logic [ADC_W-1:0]     RAIL_LVL [NUM_RAILS];
  pswm_window_t         RAIL_WIN [NUM_RAILS];
  pswm_state_t          SLEEP_STATE;
  logic                 SYS_PWR_EN, USB_PWR_EN, FAN_EN, INTRUSION, WAKE_EVENT;
  logic [DUTY_W-1:0]    FAN_DUTY [NUM_FANS];
  logic [NUM_RAILS-1:0] RAIL_FAULT;
  int                   errors, samples_checked, cycles;

  pswm_top #(.HOLD_LIMIT(HOLD)) dut (
    .MCLK(MCLK), .RST_N(RST_N), .PWR_SW(PWR_SW), .WAKE_IN(WAKE_IN),
    .PCIE_WAKE_EN(PCIE_WAKE_EN), .OS_CMD(OS_CMD), .INTRUSION_SW(INTRUSION_SW),
    .INTRUSION_CLR(INTRUSION_CLR), .HUB_TEMP_RAW(HUB_TEMP_RAW), .CPU_TEMP(CPU_TEMP),
    .AMB_TEMP(AMB_TEMP), .RAIL_LVL(RAIL_LVL), .RAIL_WIN(RAIL_WIN), .FAN_TICK(FAN_TICK),
    .SLEEP_STATE(SLEEP_STATE), .SYS_PWR_EN(SYS_PWR_EN), .USB_PWR_EN(USB_PWR_EN),
    .FAN_EN(FAN_EN), .FAN_DUTY(FAN_DUTY), .INTRUSION(INTRUSION), .HUB_TEMP(HUB_TEMP),
    .RAIL_FAULT(RAIL_FAULT), .WAKE_EVENT(WAKE_EVENT)
  );
  pswm_switch_model sw_model (.clk(MCLK), .sw(PWR_SW));

  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    FAN_TICK <= ~FAN_TICK;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic os(input logic [3:0] c);
    @(posedge MCLK) OS_CMD <= pswm_cmd_t'(c);
    @(posedge MCLK) OS_CMD <= '0;
  endtask

  task automatic wake(input logic [6:0] w);
    @(posedge MCLK) WAKE_IN <= pswm_wake_t'(w);
    @(posedge MCLK) WAKE_IN <= '0;
    #1;
  endtask

  task automatic wst(input pswm_state_t e);
    int n;
    n = 0;
    while (SLEEP_STATE !== e && n < 6000) begin
      @(posedge MCLK);
      n++;
    end
    #1;
    chk(SLEEP_STATE, e);
  endtask

  task automatic t_reset;
    chk(SLEEP_STATE, PSWM_S5);
    chk({SYS_PWR_EN, USB_PWR_EN, FAN_EN, INTRUSION}, 4'h0);
    chk(HUB_TEMP, GMH_FLOOR_C);
    chk(RAIL_FAULT, 5'h00);
    $display("test reset done");
  endtask

  task automatic t_on;
    sw_model.press(SHORT);
    wst(PSWM_S0);
    chk({SYS_PWR_EN, USB_PWR_EN, FAN_EN}, 3'h7);
    repeat (40) @(posedge MCLK);
    #1;
    for (int i = 0; i < NUM_FANS; i++) chk(FAN_DUTY[i] > 8'h40, 1'b1);
    $display("test power on done");
  endtask

  task automatic t_mon;
    logic [7:0] v [4] = '{8'h30, 8'h42, 8'h43, 8'h7F};
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK) HUB_TEMP_RAW <= v[i];
      repeat (2) @(posedge MCLK);
      #1;
      chk(HUB_TEMP, (v[i] > GMH_FLOOR_C) ? v[i] : GMH_FLOOR_C);
    end
    for (int r = 0; r < NUM_RAILS; r++) begin
      @(posedge MCLK) RAIL_LVL[r] <= r[0] ? 10'h063 : 10'h0C9;
      repeat (2) @(posedge MCLK);
      #1;
      chk(RAIL_FAULT, 5'h01 << r);
      @(posedge MCLK) RAIL_LVL[r] <= 10'h096;
    end
    @(posedge MCLK) INTRUSION_SW <= 1'b1;
    repeat (3) @(posedge MCLK) INTRUSION_SW <= 1'b0;
    #1;
    chk(INTRUSION, 1'b1);
    @(posedge MCLK) INTRUSION_CLR <= 1'b1;
    @(posedge MCLK) INTRUSION_CLR <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    chk(INTRUSION, 1'b0);
    $display("test monitors done");
  endtask

  task automatic t_wake;
    @(posedge MCLK) PCIE_WAKE_EN <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      os(4'b0100);
      wst(PSWM_S3);
      chk({FAN_EN, FAN_DUTY[0]}, 9'h000);
      wake(7'h40 >> i);
      chk({SLEEP_STATE, WAKE_EVENT}, {PSWM_S0, 1'b1});
    end
    os(4'b1000);
    wst(PSWM_S1);
    wake(7'h01);
    chk({SLEEP_STATE, WAKE_EVENT}, {PSWM_S0, 1'b1});
    $display("test wake sources done");
  endtask

  task automatic t_deep;
    logic [6:0] m [3] = '{7'h01, 7'h02, 7'h08};
    os(4'b0010);
    wst(PSWM_S4);
    chk(USB_PWR_EN, 1'b0);
    @(posedge MCLK) PCIE_WAKE_EN <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wake(m[i]);
      chk({SLEEP_STATE, WAKE_EVENT}, {PSWM_S4, 1'b0});
    end
    @(posedge MCLK) PCIE_WAKE_EN <= 1'b1;
    wake(7'h08);
    chk({SLEEP_STATE, WAKE_EVENT}, {PSWM_S0, 1'b1});
    $display("test deep sleep done");
  endtask

  task automatic t_press;
    sw_model.press(SHORT);
    wst(PSWM_S3);
    sw_model.press(LONG);
    wst(PSWM_S5);
    sw_model.press(SHORT);
    wst(PSWM_S0);
    os(4'b0001);
    wst(PSWM_S5);
    chk({SYS_PWR_EN, FAN_EN}, 2'b00);
    sw_model.press(SHORT);
    wst(PSWM_S0);
    sw_model.press(LONG);
    wst(PSWM_S5);
    $display("test power switch done");
  endtask

  initial begin
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    RST_N = 1'b0;
    FAN_TICK = 1'b0;
    PCIE_WAKE_EN = 1'b0;
    INTRUSION_SW = 1'b0;
    INTRUSION_CLR = 1'b0;
    WAKE_IN = '0;
    OS_CMD = '0;
    HUB_TEMP_RAW = 8'h30;
    CPU_TEMP = 8'h60;
    AMB_TEMP = 8'h60;
    for (int r = 0; r < NUM_RAILS; r++) begin
      RAIL_LVL[r] = 10'h096;
      RAIL_WIN[r] = '{lo: 10'h064, hi: 10'h0C8};
    end
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    #1;
    t_reset();
    t_on();
    t_mon();
    t_wake();
    t_deep();
    t_press();
    final_report();
  end
endmodule
